/* File: shared/ifoa_pkg.sv */
// ==========================================
// shared constants for the instruction format and operand addressing block
// ==========================================
package ifoa_pkg;

  // widths of addresses, halfwords, fullwords, opcodes and fields
  localparam int ADDR_W = 16;
  localparam int HALF_W = 16;
  localparam int FULL_W = 32;
  localparam int OPC_W = 8;
  localparam int FLD_W = 4;

  // field positions inside the first halfword; bit 0 of the word is bit 15 here
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 8;
  localparam int FOP_MSB = 7;
  localparam int FOP_LSB = 4;
  localparam int SRF_MSB = 3;
  localparam int SRF_LSB = 0;

  // opcode bits that pick the format and the operand size
  localparam int FMT_SEL_MSB = 7;
  localparam int FMT_SEL_LSB = 6;
  localparam int SIZE_SEL_MSB = 5;
  localparam int SIZE_SEL_LSB = 4;
  localparam logic [1:0] FMT_SEL_RR = 2'h0;
  localparam logic [1:0] FMT_SEL_RS = 2'h3;
  localparam logic [1:0] SIZE_SEL_FULL = 2'h1;
  localparam logic [1:0] SIZE_SEL_BYTE = 2'h2;

  // branch on condition opcodes, one per format that carries a mask
  localparam logic [OPC_W-1:0] BRANCH_OP_RR = 8'h02;
  localparam logic [OPC_W-1:0] BRANCH_OP_RX = 8'h42;

  // address steps and the index field value that means no indexing
  localparam logic [ADDR_W-1:0] HALF_STEP = 16'h0002;
  localparam logic [ADDR_W-1:0] FULL_STEP = 16'h0004;
  localparam logic [FLD_W-1:0] NO_INDEX = 4'h0;

  // reset values
  localparam logic [ADDR_W-1:0] IA_RST = 16'h0000;
  localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
  localparam logic [FULL_W-1:0] FULL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {FMT_RR = 2'h0, FMT_RX = 2'h1, FMT_RS = 2'h2} ifoa_fmt_t;
  typedef enum logic [1:0] {SZ_HALF = 2'h0, SZ_FULL = 2'h1, SZ_BYTE = 2'h2} ifoa_size_t;

  // gray coded along fetch, fetch, register, operand, operand, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH1 = 3'h1,
    ST_FETCH2 = 3'h3,
    ST_REGRD = 3'h2,
    ST_OPRD = 3'h6,
    ST_OPRD2 = 3'h7,
    ST_DONE = 3'h5
  } ifoa_state_t;

endpackage : ifoa_pkg

/* File: hdl/ifoa_field_split.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// field extraction from the first instruction halfword
// ==========================================
module ifoa_field_split
  import ifoa_pkg::*;
(
  // instruction halfword
  input wire logic [HALF_W-1:0] hw,
  // extracted fields
  output logic [OPC_W-1:0] operation_code_field,
  output logic [FLD_W-1:0] first_operand_field,
  output logic [FLD_W-1:0] second_register_field,
  // classification
  output ifoa_fmt_t fmt,
  output ifoa_size_t size,
  output logic is_branch
);

  // fixed field slices, leftmost bit is the top bit
  assign operation_code_field = hw[OPC_MSB:OPC_LSB];
  assign first_operand_field = hw[FOP_MSB:FOP_LSB];
  assign second_register_field = hw[SRF_MSB:SRF_LSB];

  // format from the top opcode bits
  always_comb
  begin
    if (hw[FMT_SEL_MSB+OPC_LSB:FMT_SEL_LSB+OPC_LSB] == FMT_SEL_RR)
      fmt = FMT_RR;
    else if (hw[FMT_SEL_MSB+OPC_LSB:FMT_SEL_LSB+OPC_LSB] == FMT_SEL_RS)
      fmt = FMT_RS;
    else
      fmt = FMT_RX;
  end

  // operand size for memory operands
  always_comb
  begin
    if (hw[SIZE_SEL_MSB+OPC_LSB:SIZE_SEL_LSB+OPC_LSB] == SIZE_SEL_FULL)
      size = SZ_FULL;
    else if (hw[SIZE_SEL_MSB+OPC_LSB:SIZE_SEL_LSB+OPC_LSB] == SIZE_SEL_BYTE)
      size = SZ_BYTE;
    else
      size = SZ_HALF;
  end

  // branch on condition takes its first field as a mask
  assign is_branch = (operation_code_field == BRANCH_OP_RR) || (operation_code_field == BRANCH_OP_RX);

endmodule : ifoa_field_split
`default_nettype wire

/* File: hdl/ifoa_byte_lane.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// byte lane selection out of one memory halfword
// ==========================================
module ifoa_byte_lane
  import ifoa_pkg::*;
(
  // halfword from memory and access shape
  input wire logic [HALF_W-1:0] hw,
  input wire logic addr_lsb,
  input wire ifoa_size_t size,
  // selected data, bytes zero extended
  output logic [HALF_W-1:0] lane
);

  // even byte address is the left byte, odd the right one
  always_comb
  begin
    if (size != SZ_BYTE)
      lane = hw;
    else if (addr_lsb)
      lane = {8'h00, hw[7:0]};
    else
      lane = {8'h00, hw[15:8]};
  end

endmodule : ifoa_byte_lane
`default_nettype wire

/* File: hdl/ifoa_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ifoa_top
  import ifoa_pkg::*;
(
  // clock, reset and enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // control from the core
  input wire logic start,
  input wire logic ia_load,
  input wire logic [ADDR_W-1:0] ia_value,
  input wire logic [FLD_W-1:0] cond_code,
  // memory bus, one halfword per request
  output logic mem_req_r,
  output logic [ADDR_W-1:0] mem_addr_r,
  input wire logic mem_ack,
  input wire logic [HALF_W-1:0] mem_rdata,
  // general register read ports, data in the same cycle as the address
  output logic [FLD_W-1:0] gr1_addr_r,
  output logic [FLD_W-1:0] gr2_addr_r,
  input wire logic [HALF_W-1:0] gr1_data,
  input wire logic [HALF_W-1:0] gr2_data,
  // decoded instruction and operands
  output logic busy_r,
  output logic done_r,
  output logic [1:0] fmt_r,
  output logic [OPC_W-1:0] opcode_r,
  output logic [HALF_W-1:0] op1_r,
  output logic [FULL_W-1:0] op2_r,
  output logic [ADDR_W-1:0] ea_r,
  output logic [ADDR_W-1:0] ia_r,
  output logic align_err_r,
  output logic is_branch_r,
  output logic branch_taken_r
);

  // ==========================================
  // internal state
  // ==========================================
  ifoa_state_t state_r;
  ifoa_state_t state_nxt;
  logic [HALF_W-1:0] hw1_r;
  logic [HALF_W-1:0] addr_fld_r;
  logic [HALF_W-1:0] hi_half_r;
  ifoa_size_t size_r;
  ifoa_fmt_t dec_fmt_r;

  // field split outputs
  logic [HALF_W-1:0] dec_src;
  logic [OPC_W-1:0] dec_opc;
  logic [FLD_W-1:0] dec_fop;
  logic [FLD_W-1:0] dec_srf;
  ifoa_fmt_t dec_fmt;
  ifoa_size_t dec_size;
  logic dec_branch;

  // address arithmetic and checks
  logic [ADDR_W-1:0] index_val;
  logic [ADDR_W-1:0] ea_nxt;
  logic misaligned;
  logic need_mem;
  logic [HALF_W-1:0] lane;
  logic [FLD_W-1:0] cc_hit;

  // ==========================================
  // field extraction
  // ==========================================
  // decode straight off the bus while the first halfword arrives
  assign dec_src = (state_r == ST_FETCH1) ? mem_rdata : hw1_r;

  ifoa_field_split u_split (
    .hw(dec_src),
    .operation_code_field(dec_opc),
    .first_operand_field(dec_fop),
    .second_register_field(dec_srf),
    .fmt(dec_fmt),
    .size(dec_size),
    .is_branch(dec_branch)
  );

  ifoa_byte_lane u_lane (
    .hw(mem_rdata),
    .addr_lsb(ea_r[0]),
    .size(size_r),
    .lane(lane)
  );

  // ==========================================
  // address formation
  // ==========================================
  // register zero never indexes, so the field itself gates the add
  assign index_val = (dec_srf == NO_INDEX) ? HALF_RST : gr2_data;
  // plain 16-bit wrap; the register value may be signed
  assign ea_nxt = addr_fld_r + index_val;

  // alignment follows the leftmost byte address of the operand
  always_comb
  begin
    misaligned = 1'b0;
    if (dec_size == SZ_HALF)
      misaligned = ea_nxt[0];
    else if (dec_size == SZ_FULL)
      misaligned = |ea_nxt[1:0];
  end

  // only indexed memory format touches memory for its operand
  assign need_mem = (dec_fmt_r == FMT_RX) && !dec_branch && !misaligned;

  // condition code test, one bit per mask position
  genvar gi;
  generate
    for (gi = 0; gi < FLD_W; gi++)
    begin : g_cc
      assign cc_hit[gi] = dec_fop[gi] & cond_code[gi];
    end
  endgenerate

  // ==========================================
  // sequencing
  // ==========================================
  // next state; a stalled bus simply holds the current state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
          state_nxt = ST_FETCH1;
      end
      ST_FETCH1:
      begin
        if (mem_ack)
          state_nxt = (dec_fmt == FMT_RR) ? ST_REGRD : ST_FETCH2;
      end
      ST_FETCH2:
      begin
        if (mem_ack)
          state_nxt = ST_REGRD;
      end
      ST_REGRD:
      begin
        state_nxt = need_mem ? ST_OPRD : ST_DONE;
      end
      ST_OPRD:
      begin
        if (mem_ack)
          state_nxt = (size_r == SZ_FULL) ? ST_OPRD2 : ST_DONE;
      end
      ST_OPRD2:
      begin
        if (mem_ack)
          state_nxt = ST_DONE;
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_r <= ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // busy and completion flags
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      busy_r <= (state_nxt != ST_IDLE);
      done_r <= (state_r == ST_DONE);
    end
  end

  // ==========================================
  // memory bus requests
  // ==========================================
  // request holds until acknowledged; a new one starts on each read state entry
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_req_r <= 1'b0;
      mem_addr_r <= IA_RST;
    end
    else if (ce)
    begin
      if (mem_ack)
        mem_req_r <= 1'b0;
      if (state_nxt != state_r)
      begin
        case (state_nxt)
          ST_FETCH1:
          begin
            mem_req_r <= 1'b1;
            mem_addr_r <= ia_r;
          end
          ST_FETCH2:
          begin
            mem_req_r <= 1'b1;
            mem_addr_r <= ia_r + HALF_STEP;
          end
          ST_OPRD:
          begin
            mem_req_r <= 1'b1;
            mem_addr_r <= {ea_nxt[ADDR_W-1:1], 1'b0};
          end
          ST_OPRD2:
          begin
            mem_req_r <= 1'b1;
            mem_addr_r <= ea_r + HALF_STEP;
          end
          default:
          begin
            mem_addr_r <= mem_addr_r;
          end
        endcase
      end
    end
  end

  // ==========================================
  // instruction capture
  // ==========================================
  // first halfword and address field kept for the rest of the sequence
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      hw1_r <= HALF_RST;
      addr_fld_r <= HALF_RST;
      size_r <= SZ_HALF;
      dec_fmt_r <= FMT_RR;
    end
    else if (ce)
    begin
      if (state_r == ST_FETCH1 && mem_ack)
      begin
        hw1_r <= mem_rdata;
        size_r <= dec_size;
        dec_fmt_r <= dec_fmt;
        addr_fld_r <= HALF_RST;
      end
      if (state_r == ST_FETCH2 && mem_ack)
        addr_fld_r <= mem_rdata;
    end
  end

  // register read addresses set as the instruction completes its fetch
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      gr1_addr_r <= NO_INDEX;
      gr2_addr_r <= NO_INDEX;
    end
    else if (ce && (state_nxt == ST_REGRD) && (state_r != ST_REGRD))
    begin
      gr1_addr_r <= dec_fop;
      gr2_addr_r <= dec_srf;
    end
  end

  // ==========================================
  // operand formation
  // ==========================================
  // first operand, mask or register contents
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      op1_r <= HALF_RST;
      opcode_r <= 8'h00;
      fmt_r <= FMT_RR;
      is_branch_r <= 1'b0;
      branch_taken_r <= 1'b0;
      align_err_r <= 1'b0;
      ea_r <= IA_RST;
    end
    else if (ce && state_r == ST_REGRD)
    begin
      opcode_r <= dec_opc;
      fmt_r <= dec_fmt_r;
      is_branch_r <= dec_branch;
      branch_taken_r <= dec_branch && (|cc_hit);
      if (dec_branch)
        op1_r <= {12'h000, dec_fop};
      else
        op1_r <= gr1_data;
      // misalignment only matters for memory operands
      align_err_r <= (dec_fmt_r == FMT_RX) && !dec_branch && misaligned;
      ea_r <= (dec_fmt_r == FMT_RR) ? IA_RST : ea_nxt;
    end
  end

  // second operand from register, immediate or memory
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      op2_r <= FULL_RST;
      hi_half_r <= HALF_RST;
    end
    else if (ce)
    begin
      if (state_r == ST_REGRD)
      begin
        case (dec_fmt_r)
          FMT_RR:
            op2_r <= {16'h0000, gr2_data};
          FMT_RS:
            op2_r <= {{HALF_W{ea_nxt[ADDR_W-1]}}, ea_nxt};
          default:
            op2_r <= {16'h0000, ea_nxt}; // branch target or failed access
        endcase
      end
      else if (state_r == ST_OPRD && mem_ack)
      begin
        // high half held back until the second read lands
        hi_half_r <= mem_rdata;
        op2_r <= {16'h0000, lane};
      end
      else if (state_r == ST_OPRD2 && mem_ack)
        op2_r <= {hi_half_r, mem_rdata};
    end
  end

  // ==========================================
  // instruction address
  // ==========================================
  // loads only while idle so a sequence never sees the address move
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ia_r <= IA_RST;
    else if (ce)
    begin
      if (state_r == ST_IDLE && ia_load && !start)
        ia_r <= {ia_value[ADDR_W-1:1], 1'b0};
      else if (state_r == ST_DONE)
        ia_r <= ia_r + ((dec_fmt_r == FMT_RR) ? HALF_STEP : FULL_STEP);
    end
  end

endmodule : ifoa_top
`default_nettype wire

/* File: verif/ifoa_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// core memory block, halfword reads only
// ==========================================
module ifoa_mem_model
  import ifoa_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // wait cycles before each answer
  input wire logic [3:0] stall,
  // memory bus
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic mem_ack,
  output logic [HALF_W-1:0] mem_rdata
);
  logic [HALF_W-1:0] store [256];
  logic [HALF_W-1:0] dat_r;
  logic [3:0] wait_r;

  // one halfword per answer; the byte address picks its containing halfword
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ack <= 1'b0;
      dat_r <= 16'h0000;
      wait_r <= 4'h0;
    end
    else if (mem_req && !mem_ack && wait_r == stall)
    begin
      mem_ack <= 1'b1;
      dat_r <= store[mem_addr[8:1]];
      wait_r <= 4'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack)
        wait_r <= wait_r + 4'h1;
    end
  end

  // data only holds with ack; inverted otherwise so stale reuse shows up
  assign mem_rdata = mem_ack ? dat_r : ~dat_r;
endmodule : ifoa_mem_model
`default_nettype wire

/* File: verif/ifoa_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bus and result checks at the top ports
// ==========================================
module ifoa_assertions
  import ifoa_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // memory side
  input wire logic mem_req_r,
  input wire logic [ADDR_W-1:0] mem_addr_r,
  input wire logic mem_ack,
  // core side
  input wire logic [FLD_W-1:0] cond_code,
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic [1:0] fmt_r,
  input wire logic [HALF_W-1:0] op1_r,
  input wire logic [FULL_W-1:0] op2_r,
  input wire logic [ADDR_W-1:0] ea_r,
  input wire logic [ADDR_W-1:0] ia_r,
  input wire logic align_err_r,
  input wire logic is_branch_r,
  input wire logic branch_taken_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [ADDR_W-1:0] ia_start_r;

  // start address tracked while idle; frozen once a sequence runs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ia_start_r <= IA_RST;
    else if (!busy_r)
      ia_start_r <= ia_r;
  end

  sequence s_b2b;
    mem_req_r && mem_ack ##1 mem_req_r;
  endsequence
  sequence s_begin;
    $rose(busy_r);
  endsequence

  AST_ADDR_EVEN: assert property (mem_req_r |-> !mem_addr_r[0])
    else $error("odd memory address");
  AST_REQ_HOLD: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("request dropped early");
  AST_SECOND_HALF: assert property (s_b2b |-> mem_addr_r == $past(mem_addr_r) + HALF_STEP)
    else $error("second read not at next halfword");
  AST_FETCH_AT_IA: assert property (s_begin |-> mem_req_r && mem_addr_r == ia_r)
    else $error("fetch not at instruction address");
  AST_IDLE_QUIET: assert property (!busy_r |-> !mem_req_r)
    else $error("read while idle");
  AST_SEQ_BOUND: assert property (s_begin |-> ##[4:60] done_r)
    else $error("sequence too long");
  AST_IA_STEP: assert property (done_r |->
    ia_r == ia_start_r + ((fmt_r == 2'h0) ? HALF_STEP : FULL_STEP))
    else $error("instruction address step wrong");
  AST_BRANCH_MASK: assert property (done_r && is_branch_r |-> op1_r[15:4] == 12'h000)
    else $error("branch mask not alone");
  // condition code is sampled in the register state, two edges before done is seen
  AST_BRANCH_TAKEN: assert property (done_r |-> branch_taken_r ==
    (is_branch_r && |(op1_r[3:0] & $past(cond_code, 2))))
    else $error("branch decision wrong");
  AST_ALIGN: assert property (done_r && align_err_r |->
    ea_r[1:0] != 2'h0 && op2_r == {16'h0000, ea_r})
    else $error("alignment flag wrong");
  AST_RS_SIGNED: assert property (done_r && fmt_r == 2'h2 |-> op2_r[31:16] == {16{op2_r[15]}})
    else $error("immediate not signed");
  AST_RR_NO_EA: assert property (done_r && fmt_r == 2'h0 |-> ea_r == 16'h0000)
    else $error("register format with address");
endmodule : ifoa_assertions

bind ifoa_top ifoa_assertions i_chk (.clock(clock), .rstn(rstn), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
  .mem_ack(mem_ack), .cond_code(cond_code), .busy_r(busy_r), .done_r(done_r), .fmt_r(fmt_r), .op1_r(op1_r),
  .op2_r(op2_r), .ea_r(ea_r), .ia_r(ia_r), .align_err_r(align_err_r), .is_branch_r(is_branch_r),
  .branch_taken_r(branch_taken_r));
`default_nettype wire

/* File: verif/instr_format_operand_addressing_test.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// decoder bench: one task per scenario
// ==========================================
module instr_format_operand_addressing_test;
  logic clock = 1'b0, rstn = 1'b0, ce = 1'b1, start = 1'b0, ia_load = 1'b0;
  logic [15:0] ia_value = 16'h0000, cur_at, gr1_data, gr2_data;
  logic [3:0] cond_code = 4'h0, stall = 4'h0, gr1_addr_r, gr2_addr_r;
  logic mem_req_r, mem_ack, busy_r, done_r, align_err_r, is_branch_r, branch_taken_r;
  logic [15:0] mem_addr_r, mem_rdata, op1_r, ea_r, ia_r, regs [16];
  logic [1:0] fmt_r;
  logic [7:0] opcode_r;
  logic [31:0] op2_r;
  int bad_count = 0, samples_checked = 0;

  ifoa_top i_dut (.clock(clock), .rstn(rstn), .ce(ce), .start(start), .ia_load(ia_load), .ia_value(ia_value),
    .cond_code(cond_code), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .gr1_addr_r(gr1_addr_r), .gr2_addr_r(gr2_addr_r), .gr1_data(gr1_data),
    .gr2_data(gr2_data), .busy_r(busy_r), .done_r(done_r), .fmt_r(fmt_r), .opcode_r(opcode_r), .op1_r(op1_r),
    .op2_r(op2_r), .ea_r(ea_r), .ia_r(ia_r), .align_err_r(align_err_r), .is_branch_r(is_branch_r),
    .branch_taken_r(branch_taken_r));
  ifoa_mem_model i_mem (.clock(clock), .rstn(rstn), .stall(stall), .mem_req(mem_req_r), .mem_addr(mem_addr_r),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // register file read; the address is already a flop, so a second flop here would be a cycle late
  assign gr1_data = regs[gr1_addr_r];
  assign gr2_data = regs[gr2_addr_r];

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : chk_val

  // place one instruction, optionally load its address, start and wait for done
  task automatic run(input logic [15:0] at, input logic [15:0] hw1, input logic [15:0] hw2, input bit load);
    int n;
    begin
      i_mem.store[at[8:1]] = hw1;
      i_mem.store[at[8:1] + 8'h01] = hw2;
      cur_at = at;
      @(posedge clock);
      if (load)
      begin
        ia_load <= 1'b1;
        ia_value <= at;
        @(posedge clock);
        ia_load <= 1'b0;
      end
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      n = 0;
      do
      begin
        @(negedge clock);
        n++;
      end
      while (done_r !== 1'b1 && n < 100);
      chk_val("done", 32'h0000_0001, {31'h0, done_r});
    end
  endtask : run

  task automatic expect_res(input logic [7:0] opc, input logic [1:0] f, input logic [15:0] o1,
    input logic [31:0] o2, input logic [15:0] e, input logic ae);
    begin
      chk_val("opcode", {24'h0, opc}, {24'h0, opcode_r});
      chk_val("format", {30'h0, f}, {30'h0, fmt_r});
      chk_val("op1", {16'h0, o1}, {16'h0, op1_r});
      chk_val("op2", o2, op2_r);
      chk_val("ea", {16'h0, e}, {16'h0, ea_r});
      chk_val("ia", {16'h0, cur_at + ((f == 2'h0) ? 16'h0002 : 16'h0004)}, {16'h0, ia_r});
      chk_val("align", {31'h0, ae}, {31'h0, align_err_r});
    end
  endtask : expect_res

  task automatic t_rr;
    begin
      run(16'h0100, 16'h0837, 16'h0000, 1'b1);
      expect_res(8'h08, 2'h0, regs[3], {16'h0, regs[7]}, 16'h0000, 1'b0);
      run(16'h0100, 16'h08F1, 16'h0000, 1'b1);
      expect_res(8'h08, 2'h0, regs[15], {16'h0, regs[1]}, 16'h0000, 1'b0);
      $display("register format test done");
    end
  endtask : t_rr

  // slow memory: three wait cycles on each read
  task automatic t_rx;
    begin
      @(posedge clock);
      stall <= 4'h3;
      run(16'h0100, 16'h4850, 16'h0050, 1'b1);
      expect_res(8'h48, 2'h1, regs[5], 32'h0000_0123, 16'h0050, 1'b0);
      run(16'h0100, 16'h5850, 16'h0050, 1'b1);
      expect_res(8'h58, 2'h1, regs[5], 32'h0123_4567, 16'h0050, 1'b0);
      run(16'h0100, 16'h5852, 16'h0050, 1'b1);
      expect_res(8'h58, 2'h1, regs[5], 32'h89AB_CDEF, 16'h0054, 1'b0);
      @(posedge clock);
      stall <= 4'h0;
      $display("indexed memory test done");
    end
  endtask : t_rx

  task automatic t_byte;
    begin
      for (int k = 0; k < 8; k++)
      begin
        run(16'h0100, 16'h6850, 16'h0050 + 16'(k), 1'b1);
        expect_res(8'h68, 2'h1, regs[5], {24'h0, 8'(8'h01 + 8'h22 * k)}, 16'h0050 + 16'(k),
          1'b0);
      end
      $display("byte access test done");
    end
  endtask : t_byte

  task automatic t_align;
    begin
      run(16'h0100, 16'h4850, 16'h0051, 1'b1);
      expect_res(8'h48, 2'h1, regs[5], 32'h0000_0051, 16'h0051, 1'b1);
      run(16'h0100, 16'h5850, 16'h0052, 1'b1);
      expect_res(8'h58, 2'h1, regs[5], 32'h0000_0052, 16'h0052, 1'b1);
      $display("alignment test done");
    end
  endtask : t_align

  task automatic t_rs;
    begin
      run(16'h0100, 16'hC852, 16'hFFF0, 1'b1);
      expect_res(8'hC8, 2'h2, regs[5], 32'hFFFF_FFF4, 16'hFFF4, 1'b0);
      run(16'h0100, 16'hC850, 16'h7FFF, 1'b1);
      expect_res(8'hC8, 2'h2, regs[5], 32'h0000_7FFF, 16'h7FFF, 1'b0);
      $display("storage format test done");
    end
  endtask : t_rs

  // condition held steady for the whole sequence
  task automatic t_branch;
    logic [15:0] hw1 [3] = '{16'h0250, 16'h0250, 16'h4290};
    logic [3:0] cc [3] = '{4'h4, 4'h2, 4'h8};
    logic [31:0] o2 [3] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_1234};
    begin
      for (int k = 0; k < 3; k++)
      begin
        @(posedge clock);
        cond_code <= cc[k];
        run(16'h0100, hw1[k], 16'h1234, 1'b1);
        expect_res(hw1[k][15:8], {1'b0, hw1[k][14]}, {12'h0, hw1[k][7:4]}, o2[k],
          hw1[k][14] ? 16'h1234 : 16'h0000, 1'b0);
        chk_val("branch", 32'h0000_0001, {31'h0, is_branch_r});
        chk_val("taken", {31'h0, |(hw1[k][7:4] & cc[k])}, {31'h0, branch_taken_r});
      end
      $display("branch test done");
    end
  endtask : t_branch

  // halfword then fullword with no reload in between
  task automatic t_mix;
    begin
      run(16'h0104, 16'h0837, 16'h0000, 1'b1);
      expect_res(8'h08, 2'h0, regs[3], {16'h0, regs[7]}, 16'h0000, 1'b0);
      run(16'h0106, 16'h4850, 16'h0052, 1'b0);
      expect_res(8'h48, 2'h1, regs[5], 32'h0000_4567, 16'h0052, 1'b0);
      $display("mixed format test done");
    end
  endtask : t_mix

  task automatic finish_test;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask : finish_test

  // reset, contents, scenarios
  initial
  begin
    for (int i = 0; i < 16; i++)
      regs[i] = 16'h0A00 + 16'(i);
    regs[0] = 16'h0010;
    regs[2] = 16'h0004;
    i_mem.store[8'h28] = 16'h0123;
    i_mem.store[8'h29] = 16'h4567;
    i_mem.store[8'h2A] = 16'h89AB;
    i_mem.store[8'h2B] = 16'hCDEF;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_rr();
    t_rx();
    t_byte();
    t_align();
    t_rs();
    t_branch();
    t_mix();
    finish_test();
  end

  // hang guard at 8000 cycles, far beyond the few hundred cycles needed
  initial
  begin
    #(25 * 8000);
    bad_count++;
    finish_test();
  end
endmodule : instr_format_operand_addressing_test
`default_nettype wire
